// *** rtl/emac_wake_collision.sv ***
// MAC slice: APB registers, PHY management port, wake pattern detection,
// soft reset, interrupt, and preamble-collision jam with retransmission wait.
// Assumes APB on mclk; MII pins and link clocks are asynchronous to mclk.
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/10ps
module emac_wake_collision
	import emac_pkg::*;
#(
	parameter int BACKOFF_CYCLES = 64,
	parameter int MAX_RETRIES = 15
)
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic txClk,
	output logic txEn,
	output logic [3:0] txd,
	input wire logic col,
	input wire logic rxClk,
	input wire logic rxDv,
	input wire logic [3:0] rxd,
	output logic mdc,
	input wire logic mdioIn,
	output logic mdioOut,
	output logic mdioOe_n,
	output logic wake_output_pin,
	output logic irq,
	input wire logic chipStandby,
	input wire logic moduleStandby
);
	`include "emac_map.svh"

	// ------------------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------------------
	logic [8:0] pinLevel;
	logic [8:0] pinRise;

	sync_bus #(.WIDTH(9)) u_sync
	(
		.mclk(mclk),
		.reset_n(reset_n),
		.pinIn({mdioIn, col, rxDv, rxd, rxClk, txClk}),
		.level(pinLevel),
		.rise(pinRise)
	);

	wire txRise = pinRise[0];
	wire rxRise = pinRise[1];
	wire [3:0] rxdSync = pinLevel[5:2];
	wire rxDvSync = pinLevel[6];
	wire colSync = pinLevel[7];
	wire mdioSync = pinLevel[8];

	// ------------------------------------------------------------------------
	// Run control and soft reset
	// ------------------------------------------------------------------------
	logic [4:0] swrCnt_ff;
	logic [1:0] mode_ff;
	logic [2:0] irqEn_ff;
	event_t status_ff;
	logic [2:0] phyPort_ff;
	logic [47:0] stationAddr_ff;
	logic [7:0] txByte_ff;
	logic [7:0] txLen_ff;
	logic txGo_ff;
	logic wake_ff;
	logic [31:0] prdata_ff;

	// module standby ignored
	// The module-standby input is deliberately left unused: the MAC cannot be stopped that way.
	wire runEn = ~chipStandby;
	wire swrActive = (swrCnt_ff != 5'h00);

	assign pready = runEn & ~swrActive;
	wire setup = psel & ~penable;
	wire access = psel & penable & pready;
	wire wrAcc = access & pwrite;

	wire selMode = (paddr == `OFS_MODE);
	wire selStatus = (paddr == `OFS_STATUS);
	wire selIrqEn = (paddr == `OFS_IRQ_EN);
	wire selPhy = (paddr == `OFS_PHY_PORT);
	wire selDma = (paddr == `OFS_DMA_MODE);
	wire selAddrLo = (paddr == `OFS_ADDR_LO);
	wire selAddrHi = (paddr == `OFS_ADDR_HI);
	wire selTxc = (paddr == `OFS_TX_CTRL);
	wire mapped = selMode | selStatus | selIrqEn | selPhy | selDma | selAddrLo | selAddrHi | selTxc;
	assign pslverr = access & ~mapped;

	wire swrStart = wrAcc & selDma & pwdata[`DMA_SOFT_RESET];
	wire wakeDetEn = mode_ff[`MODE_WAKE_DET];
	wire jamWithSfd = mode_ff[`MODE_JAM_SFD];

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			swrCnt_ff <= 5'h00;
		else if (swrStart)
			swrCnt_ff <= `SOFT_RESET_CYCLES;
		else if (swrActive && runEn)
			swrCnt_ff <= swrCnt_ff - 5'h01;
	end

	// ------------------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------------------
	// PHY bit port
	// Software toggles the management clock and data one bit at a time; no framing here.
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mode_ff <= `MODE_RESET;
			irqEn_ff <= 3'h0;
			phyPort_ff <= 3'h0;
			stationAddr_ff <= 48'h0;
			txByte_ff <= 8'h00;
			txLen_ff <= 8'h00;
		end
		else if (swrActive)
		begin
			mode_ff <= `MODE_RESET;
			irqEn_ff <= 3'h0;
			phyPort_ff <= 3'h0;
		end
		else if (wrAcc)
		begin
			if (selMode)
				mode_ff <= pwdata[1:0];
			if (selIrqEn)
				irqEn_ff <= pwdata[2:0];
			if (selPhy)
				phyPort_ff <= pwdata[2:0];
			if (selAddrLo)
				stationAddr_ff[31:0] <= pwdata;
			if (selAddrHi)
				stationAddr_ff[47:32] <= pwdata[15:0];
			if (selTxc)
			begin
				txByte_ff <= pwdata[7:0];
				txLen_ff <= pwdata[`TXC_LEN_LSB +: 8];
			end
		end
	end

	assign mdc = phyPort_ff[`PHY_CLK];
	assign mdioOut = phyPort_ff[`PHY_DOUT];
	assign mdioOe_n = ~phyPort_ff[`PHY_DIR];

	// ------------------------------------------------------------------------
	// Wake detection
	// ------------------------------------------------------------------------
	logic wakeHit;

	wake_detector u_wake
	(
		.mclk(mclk),
		.reset_n(reset_n),
		.clear(swrActive),
		.enable(wakeDetEn & runEn),
		.nibbleStrobe(rxRise),
		.rxValid(rxDvSync),
		.rxNibble(rxdSync),
		.stationAddr(stationAddr_ff),
		.hit(wakeHit)
	);

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			wake_ff <= 1'b0;
		else if (swrActive)
			wake_ff <= 1'b0;
		else if (wakeHit)
			wake_ff <= 1'b1;
	end
	assign wake_output_pin = wake_ff;

	// ------------------------------------------------------------------------
	// Transmitter with preamble collision handling
	// ------------------------------------------------------------------------
	txState_e txState_ff;
	logic [4:0] nibCnt_ff;
	logic [8:0] dataNib_ff;
	logic [3:0] retry_ff;
	logic [15:0] backoff_ff;
	logic [3:0] nxt_txd;
	logic txDoneEv;
	logic collEv;

	wire txStart = wrAcc & selTxc & pwdata[`TXC_GO] & (txState_ff == TX_IDLE);
	wire [3:0] jamIdx = `JAM_NIBBLES - nibCnt_ff[3:0];

	always_comb
	begin
		nxt_txd = `JAM_NIBBLE;
		case (txState_ff)
			TX_PRE: nxt_txd = (nibCnt_ff == 5'h01) ? `SFD_HI : `SFD_LO;
			TX_DATA: nxt_txd = dataNib_ff[0] ? txByte_ff[7:4] : txByte_ff[3:0];
			TX_JAM:
			begin
				if (jamWithSfd && jamIdx == 4'h0)
					nxt_txd = `SFD_LO;
				else if (jamWithSfd && jamIdx == 4'h1)
					nxt_txd = `SFD_HI;
			end
			default: nxt_txd = 4'h0;
		endcase
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			txState_ff <= TX_IDLE;
			nibCnt_ff <= 5'h00;
			dataNib_ff <= 9'h000;
			retry_ff <= 4'h0;
			backoff_ff <= 16'h0000;
			txEn <= 1'b0;
			txd <= 4'h0;
			txGo_ff <= 1'b0;
		end
		else if (swrActive)
		begin
			txState_ff <= TX_IDLE;
			txEn <= 1'b0;
			txd <= 4'h0;
			txGo_ff <= 1'b0;
		end
		else if (runEn)
		begin
			case (txState_ff)
				TX_IDLE:
				begin
					if (txStart)
					begin
						txState_ff <= TX_PRE;
						nibCnt_ff <= `PRE_NIBBLES;
						retry_ff <= 4'h0;
						txGo_ff <= 1'b1;
					end
				end
				TX_PRE:
				begin
					if (txRise)
					begin
						if (colSync)
						begin
							txState_ff <= TX_JAM;
							nibCnt_ff <= {1'b0, `JAM_NIBBLES};
						end
						else
						begin
							txEn <= 1'b1;
							txd <= nxt_txd;
							nibCnt_ff <= nibCnt_ff - 5'h01;
							dataNib_ff <= 9'h000;
							if (nibCnt_ff == 5'h01)
								txState_ff <= (txLen_ff == 8'h00) ? TX_JAM : TX_DATA;
						end
					end
				end
				TX_DATA:
				begin
					if (txRise)
					begin
						if (colSync)
						begin
							txState_ff <= TX_JAM;
							nibCnt_ff <= {1'b0, `JAM_NIBBLES};
						end
						else if (dataNib_ff == {txLen_ff, 1'b0})
						begin
							txEn <= 1'b0;
							txd <= 4'h0;
							txState_ff <= TX_IDLE;
							txGo_ff <= 1'b0;
						end
						else
						begin
							txd <= nxt_txd;
							dataNib_ff <= dataNib_ff + 9'h001;
						end
					end
				end
				TX_JAM:
				begin
					if (txRise)
					begin
						if (nibCnt_ff == 5'h00)
						begin
							txEn <= 1'b0;
							txd <= 4'h0;
							txState_ff <= TX_WAIT;
							backoff_ff <= 16'(BACKOFF_CYCLES);
							retry_ff <= retry_ff + 4'h1;
						end
						else
						begin
							txEn <= 1'b1;
							txd <= nxt_txd;
							nibCnt_ff <= nibCnt_ff - 5'h01;
						end
					end
				end
				TX_WAIT:
				begin
					if (retry_ff > 4'(MAX_RETRIES))
					begin
						txState_ff <= TX_IDLE;
						txGo_ff <= 1'b0;
					end
					else if (backoff_ff == 16'h0000)
					begin
						txState_ff <= TX_PRE;
						nibCnt_ff <= `PRE_NIBBLES;
					end
					else
						backoff_ff <= backoff_ff - 16'h0001;
				end
				default: txState_ff <= TX_IDLE;
			endcase
		end
	end

	assign txDoneEv = runEn & (txState_ff == TX_DATA) & txRise & ~colSync & (dataNib_ff == {txLen_ff, 1'b0});
	assign collEv = runEn & (txState_ff == TX_JAM) & txRise & (nibCnt_ff == 5'h00);

	// ------------------------------------------------------------------------
	// Status, interrupt and read-back
	// ------------------------------------------------------------------------
	wire [2:0] events = {collEv, txDoneEv, wakeHit};
	wire [2:0] w1c = (wrAcc & selStatus) ? pwdata[2:0] : 3'h0;

	// The set term is applied last so an event in the clearing cycle survives.
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			status_ff <= 3'h0;
		else if (swrActive)
			status_ff <= 3'h0;
		else
			status_ff <= (status_ff & ~w1c) | events;
	end

	assign irq = runEn & (|(status_ff & irqEn_ff));

	wire [31:0] rdMux =
		selMode ? {30'h0, mode_ff} :
		selStatus ? {29'h0, status_ff} :
		selIrqEn ? {29'h0, irqEn_ff} :
		selPhy ? {28'h0, mdioSync, phyPort_ff} :
		selDma ? {31'h0, swrActive} :
		selAddrLo ? stationAddr_ff[31:0] :
		selAddrHi ? {16'h0, stationAddr_ff[47:32]} :
		selTxc ? {15'h0, txGo_ff, txLen_ff, txByte_ff} : 32'h0;

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			prdata_ff <= 32'h0;
		else if (setup || (psel && !pwrite))
			prdata_ff <= rdMux;
	end
	assign prdata = prdata_ff;

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);

	swr_length_a: assert property ((swrStart && runEn) |=> swrActive [*8] ##1 swrActive [*8] ##1 !swrActive)
		else $error("soft reset did not last sixteen clocks");
	swr_stall_a: assert property (swrActive |-> !pready)
		else $error("ready given during soft reset");
	wake_gate_a: assert property (wakeHit |-> $past(wakeDetEn))
		else $error("wake detected while detection disabled");
	wake_raise_a: assert property ((wakeHit && !swrActive) |=> wake_output_pin && status_ff[`EV_WAKE])
		else $error("wake hit did not raise pin and status");
	wake_hold_a: assert property ((wake_output_pin && !swrActive) |=> wake_output_pin)
		else $error("wake pin dropped without soft reset");
	irq_mask_a: assert property ((status_ff == 3'h1 && !irqEn_ff[`EV_WAKE]) |-> !irq)
		else $error("masked wake event reached the interrupt");
	standby_irq_a: assert property (chipStandby |-> !irq && !pready)
		else $error("interrupt or ready during chip standby");
	coll_jam_a: assert property ((txState_ff == TX_PRE && colSync && txRise && runEn && !swrActive)
		|=> txState_ff == TX_JAM && nibCnt_ff == {1'b0, `JAM_NIBBLES})
		else $error("preamble collision did not start jam");
	jam_wait_a: assert property (collEv && !swrActive |=> txState_ff == TX_WAIT && !txEn && status_ff[`EV_COLL])
		else $error("jam end did not enter retransmission wait");
	status_set_a: assert property (events[`EV_TX_DONE] && !swrActive |=> status_ff[`EV_TX_DONE])
		else $error("status event lost");

	wake_seen_c: cover property (wakeHit ##1 irq);
	coll_seen_c: cover property (txState_ff == TX_JAM ##[1:400] txState_ff == TX_WAIT);
	tx_done_c: cover property (txDoneEv);

endmodule : emac_wake_collision

// *** rtl/emac_map.svh ***
// Register map, field positions, reset values and timing counts of the MAC block.
// Included by every design file that decodes registers or counts link nibbles.
`ifndef EMAC_MAP_SVH
`define EMAC_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_MODE 8'h00
`define OFS_STATUS 8'h04
`define OFS_IRQ_EN 8'h08
`define OFS_PHY_PORT 8'h0c
`define OFS_DMA_MODE 8'h10
`define OFS_ADDR_LO 8'h14
`define OFS_ADDR_HI 8'h18
`define OFS_TX_CTRL 8'h1c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define MODE_WAKE_DET 0
`define MODE_JAM_SFD 1
`define EV_WAKE 0
`define EV_TX_DONE 1
`define EV_COLL 2
`define PHY_CLK 0
`define PHY_DOUT 1
`define PHY_DIR 2
`define PHY_DIN 3
`define DMA_SOFT_RESET 0
`define TXC_LEN_LSB 8
`define TXC_GO 16

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define MODE_RESET 2'h0
`define SOFT_RESET_CYCLES 5'h10
`define PRE_NIBBLES 5'h10
`define JAM_NIBBLES 4'h8
`define JAM_NIBBLE 4'h6
`define SFD_LO 4'h5
`define SFD_HI 4'hd
`define WAKE_SYNC_BYTES 3'h6
`define WAKE_REPEATS 4'hf

`endif

// *** rtl/emac_pkg.sv ***
// Types shared by the MAC block files.
// Constants live in emac_map.svh; this package holds only types.
package emac_pkg;

	typedef enum logic [4:0]
	{
		TX_IDLE = 5'b00001,
		TX_PRE = 5'b00010,
		TX_DATA = 5'b00100,
		TX_JAM = 5'b01000,
		TX_WAIT = 5'b10000
	} txState_e;

	typedef logic [2:0] event_t;

endpackage : emac_pkg

// *** rtl/sync_bus.sv ***
// Two-flop synchronisers for pins from outside the mclk domain, with rise pulses.
// Assumes each pin stays stable for several mclk periods.
`timescale 1ns/10ps
module sync_bus #(parameter int WIDTH = 1)
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise
);
	logic [WIDTH-1:0] stage1_ff;
	logic [WIDTH-1:0] stage2_ff;
	logic [WIDTH-1:0] stage3_ff;

	generate
		for (genvar i = 0; i < WIDTH; i++)
		begin : g_bit
			always_ff @(posedge mclk or negedge reset_n)
			begin
				if (!reset_n)
				begin
					stage1_ff[i] <= 1'b0;
					stage2_ff[i] <= 1'b0;
					stage3_ff[i] <= 1'b0;
				end
				else
				begin
					stage1_ff[i] <= pinIn[i];
					stage2_ff[i] <= stage1_ff[i];
					stage3_ff[i] <= stage2_ff[i];
				end
			end
			assign level[i] = stage2_ff[i];
			assign rise[i] = stage2_ff[i] & ~stage3_ff[i];
		end
	endgenerate

endmodule : sync_bus

// *** rtl/wake_detector.sv ***
// Wake pattern detector: six 0xff bytes then sixteen copies of the station address.
// Assumes synchronised receive nibbles and one strobe per receive clock rise.
`timescale 1ns/10ps
module wake_detector
	import emac_pkg::*;
(
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic clear,
	input wire logic enable,
	input wire logic nibbleStrobe,
	input wire logic rxValid,
	input wire logic [3:0] rxNibble,
	input wire logic [47:0] stationAddr,
	output logic hit
);
	`include "emac_map.svh"

	logic [3:0] lowNib_ff;
	logic half_ff;
	logic [2:0] syncCnt_ff;
	logic [2:0] byteIdx_ff;
	logic [3:0] repCnt_ff;
	logic hit_ff;
	logic [7:0] addrByte;

	wire [7:0] rxByte = {rxNibble, lowNib_ff};
	wire byteDone = enable & nibbleStrobe & rxValid & half_ff;
	wire synced = (syncCnt_ff == `WAKE_SYNC_BYTES);
	wire addrMatch = synced & (rxByte == addrByte);
	wire lastByte = (byteIdx_ff == 3'h5) & (repCnt_ff == `WAKE_REPEATS);

	always_comb
	begin
		case (byteIdx_ff)
			3'h0: addrByte = stationAddr[47:40];
			3'h1: addrByte = stationAddr[39:32];
			3'h2: addrByte = stationAddr[31:24];
			3'h3: addrByte = stationAddr[23:16];
			3'h4: addrByte = stationAddr[15:8];
			default: addrByte = stationAddr[7:0];
		endcase
	end

	// Only the address inside the pattern counts; the frame's own destination is never looked at.
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			lowNib_ff <= 4'h0;
			half_ff <= 1'b0;
			syncCnt_ff <= 3'h0;
			byteIdx_ff <= 3'h0;
			repCnt_ff <= 4'h0;
			hit_ff <= 1'b0;
		end
		else if (clear || !enable || (nibbleStrobe && !rxValid))
		begin
			half_ff <= 1'b0;
			syncCnt_ff <= 3'h0;
			byteIdx_ff <= 3'h0;
			repCnt_ff <= 4'h0;
			hit_ff <= 1'b0;
		end
		else
		begin
			hit_ff <= byteDone & addrMatch & lastByte;
			if (nibbleStrobe)
			begin
				half_ff <= ~half_ff;
				if (!half_ff)
					lowNib_ff <= rxNibble;
			end
			if (byteDone && addrMatch)
			begin
				byteIdx_ff <= (byteIdx_ff == 3'h5) ? 3'h0 : byteIdx_ff + 3'h1;
				repCnt_ff <= (byteIdx_ff == 3'h5) ? repCnt_ff + 4'h1 : repCnt_ff;
				if (lastByte)
					syncCnt_ff <= 3'h0;
			end
			else if (byteDone)
			begin
				byteIdx_ff <= 3'h0;
				repCnt_ff <= 4'h0;
				if (rxByte != 8'hff)
					syncCnt_ff <= 3'h0;
				else if (!synced)
					syncCnt_ff <= syncCnt_ff + 3'h1;
			end
		end
	end

	assign hit = hit_ff;

endmodule : wake_detector

// *** dv/phy_model.sv ***
// Model of the external PHY: free-running transmit clock, framed receive stream,
// collision on demand, and a management data line with a pull-up.
// Assumes the bench calls send_frame and sets collide and phyDrv hierarchically.
`timescale 1ns/10ps
module phy_model
(
	output logic txClk,
	output logic rxClk,
	output logic rxDv,
	output logic [3:0] rxd,
	output logic col,
	input wire logic txEn,
	input wire logic [3:0] txd,
	input wire logic mdioOut,
	input wire logic mdioOe_n,
	output logic mdioIn
);
	logic collide;
	logic phyDrv;
	logic phyBit;
	int nibCnt;
	logic [3:0] nibQ[$];

	initial
	begin
		txClk = 1'b0;
		rxClk = 1'b0;
		rxDv = 1'b0;
		rxd = 4'h0;
		col = 1'b0;
		collide = 1'b0;
		phyDrv = 1'b0;
		phyBit = 1'b0;
		nibCnt = 0;
	end

	// The transmit clock of an MII PHY runs whether or not a frame is sent.
	always #24 txClk = ~txClk;

	// A released management line floats up to one through the pull-up.
	assign mdioIn = !mdioOe_n ? mdioOut : (phyDrv ? phyBit : 1'b1);

	// ----------------------------------------------------------------------------
	// Transmit capture and collision
	// ----------------------------------------------------------------------------
	always @(negedge txClk)
	begin
		if (txEn === 1'b1)
		begin
			nibQ.push_back(txd);
			nibCnt++;
			if (collide && nibCnt == 3)
				col <= 1'b1;
		end
		else
		begin
			nibCnt = 0;
			col <= 1'b0;
		end
	end

	// ----------------------------------------------------------------------------
	// Receive frame: two destination bytes, six 0xff, sixteen address copies
	// ----------------------------------------------------------------------------
	task automatic send_frame(input logic [47:0] addr);
		logic [7:0] b[$];
		b = {8'h12, 8'h34};
		repeat (6) b.push_back(8'hff);
		repeat (16)
			for (int i = 5; i >= 0; i--)
				b.push_back(addr[i*8 +: 8]);
		rxDv = 1'b1;
		foreach (b[k])
		begin
			for (int h = 0; h < 2; h++)
			begin
				rxd = h ? b[k][7:4] : b[k][3:0];
				#24 rxClk = 1'b1;
				#24 rxClk = 1'b0;
			end
		end
		rxDv = 1'b0;
		rxd = ~rxd;
	endtask : send_frame
endmodule : phy_model

// *** dv/ethernet_mac_wake_and_collision_tb.sv ***
// Self-checking bench for the MAC slice: registers, management port, wake, jam.
// Assumes emac_map.svh is on the include path and phy_model sits on the link.
`timescale 1ns/10ps
`include "emac_map.svh"
module ethernet_mac_wake_and_collision_tb;
	logic mclk = 1'b0;
	logic reset_n, psel, penable, pwrite, chipStandby, moduleStandby;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, v;
	logic pready, pslverr, lastErr, txClk, txEn, col, rxClk, rxDv;
	logic [3:0] txd, rxd;
	logic mdc, mdioIn, mdioOut, mdioOe_n, wake_output_pin, irq;
	int n_mismatch = 0;
	int samples_checked = 0;
	int n, sz;
	logic [47:0] sta = 48'h456789abcdef;

	always #2.5 mclk = ~mclk;

	emac_wake_collision #(.BACKOFF_CYCLES(64), .MAX_RETRIES(1)) dut (.mclk(mclk), .reset_n(reset_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .txClk(txClk), .txEn(txEn), .txd(txd), .col(col), .rxClk(rxClk),
		.rxDv(rxDv), .rxd(rxd), .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe_n(mdioOe_n),
		.wake_output_pin(wake_output_pin), .irq(irq), .chipStandby(chipStandby), .moduleStandby(moduleStandby));

	phy_model phy (.txClk(txClk), .rxClk(rxClk), .rxDv(rxDv), .rxd(rxd), .col(col), .txEn(txEn), .txd(txd),
		.mdioOut(mdioOut), .mdioOe_n(mdioOe_n), .mdioIn(mdioIn));

	// ----------------------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop

	// A wait that runs past its bound ends the run as a failure.
	task automatic tick(inout int k, input int lim);
		@(posedge mclk);
		k++;
		if (k > lim)
		begin
			n_mismatch++;
			report_and_stop();
		end
	endtask : tick

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1)
			tick(k, 200);
		v = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask : apb

	// ----------------------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------------------
	task automatic t_regs;
		apb(1'b0, `OFS_MODE, 32'h0);
		chk(v, 32'h0);
		apb(1'b1, 8'h40, 32'hffffffff);
		chk(lastErr, 1'b1);
		apb(1'b0, 8'h40, 32'h0);
		chk(lastErr, 1'b1);
		chk(v, 32'h0);
		$display("test regs done");
	endtask : t_regs

	task automatic t_phy;
		apb(1'b1, `OFS_PHY_PORT, 32'h7);
		chk({mdc, mdioOut, mdioOe_n}, 3'b110);
		repeat (4) @(posedge mclk);
		apb(1'b0, `OFS_PHY_PORT, 32'h0);
		chk(v[3], 1'b1);
		apb(1'b1, `OFS_PHY_PORT, 32'h0);
		phy.phyDrv <= 1'b1;
		repeat (4) @(posedge mclk);
		apb(1'b0, `OFS_PHY_PORT, 32'h0);
		chk({v[3], mdc, mdioOut, mdioOe_n}, 4'b0001);
		phy.phyDrv <= 1'b0;
		$display("test phy done");
	endtask : t_phy

	task automatic frame(input logic [47:0] a);
		phy.send_frame(a);
		repeat (8) @(posedge mclk);
	endtask : frame

	task automatic t_wake;
		apb(1'b1, `OFS_ADDR_LO, sta[31:0]);
		apb(1'b1, `OFS_ADDR_HI, {16'h0, sta[47:32]});
		frame(sta);
		chk(wake_output_pin, 1'b0);
		apb(1'b1, `OFS_MODE, 32'h1);
		frame(sta ^ 48'h1);
		chk(wake_output_pin, 1'b0);
		frame(sta);
		chk({wake_output_pin, irq}, 2'b10);
		apb(1'b0, `OFS_STATUS, 32'h0);
		chk(v[0], 1'b1);
		apb(1'b1, `OFS_IRQ_EN, 32'h1);
		chk(irq, 1'b1);
		moduleStandby <= 1'b1;
		repeat (2) @(posedge mclk);
		chk(irq, 1'b1);
		chipStandby <= 1'b1;
		repeat (2) @(posedge mclk);
		chk({irq, pready}, 2'b00);
		chipStandby <= 1'b0;
		moduleStandby <= 1'b0;
		@(posedge mclk);
		apb(1'b1, `OFS_STATUS, 32'h1);
		chk({wake_output_pin, irq}, 2'b10);
		apb(1'b1, `OFS_DMA_MODE, 32'h1);
		n = 1;
		while (pready !== 1'b1)
			tick(n, 40);
		chk(n - 1, 16);
		chk(wake_output_pin, 1'b0);
		apb(1'b0, `OFS_MODE, 32'h0);
		chk(v, 32'h0);
		$display("test wake done");
	endtask : t_wake

	task automatic t_coll;
		logic [3:0] e;
		for (int jm = 0; jm < 2; jm++)
		begin
			apb(1'b1, `OFS_MODE, {30'h0, jm[0], 1'b0});
			phy.collide = 1'b1;
			phy.nibQ.delete();
			apb(1'b1, `OFS_TX_CTRL, 32'h102a5);
			n = 0;
			while (txEn !== 1'b1)
				tick(n, 200);
			while (txEn !== 1'b0)
				tick(n, 2000);
			phy.collide = 1'b0;
			sz = phy.nibQ.size();
			chk(sz < 13, 1'b1);
			for (int i = 0; i < 8; i++)
			begin
				e = (jm == 1 && i == 0) ? `SFD_LO : (jm == 1 && i == 1) ? `SFD_HI : `JAM_NIBBLE;
				chk(phy.nibQ[sz-8+i], e);
			end
			apb(1'b0, `OFS_STATUS, 32'h0);
			chk(v[2:0], 3'b100);
			n = 0;
			while (txEn !== 1'b1)
				tick(n, 400);
			while (txEn !== 1'b0)
				tick(n, 2000);
			repeat (2) @(posedge mclk);
			apb(1'b0, `OFS_STATUS, 32'h0);
			chk(v[1], 1'b1);
			chk(phy.nibQ[phy.nibQ.size()-1], 4'ha);
			apb(1'b1, `OFS_STATUS, 32'h7);
		end
		$display("test collision done");
	endtask : t_coll

	initial
	begin
		reset_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		chipStandby = 1'b0;
		moduleStandby = 1'b0;
		repeat (8) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		t_regs();
		t_phy();
		t_wake();
		t_coll();
		report_and_stop();
	end
endmodule : ethernet_mac_wake_and_collision_tb
